// *** logic/srr_regs.sv ***
// Overview of operation
// [R1] four status registers: event, event enable, status byte, request enable
// [R2] event bits: power-on 7, user 6, command 5, exec 4, device 3, query 2, complete 0
// [R3] event register read-only; cleared by reading it or by clear-status
// [R4] event enable read/write by command; writing zero clears; zero after startup
// [R5] status byte: summary 6, event summary 5, message 4, error 2; rest unused
// [R6] status byte read by query and by serial poll without disturbing operation
// [R7] status byte not writable; clear-status empties its sources
// [R8] request enable read/write by command; zero clears; zero after startup
// [R9] raise service request and set request-service bit when attention needed
// [R10] character codes 0-9 and 11-32 classed as whitespace
// [R11] character codes 48-57 classed as digits zero to nine
// [R12] keyword with no numeric suffix applies to the first capability
// [R13] optional keywords or parameters present or absent are treated alike
// [R14] message available bit set while the output queue holds data
// [R15] error available bit set while the error queue holds an entry
// [R16] event summary is OR of event register AND enable mask
// [R17] master summary and request are OR of status bits AND request enable
`timescale 1ns/1ps
`default_nettype none
`include "srr_cfg.svh"

module srr_regs
    import srr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       cmd_valid_i,
    input  wire srr_cmd_t   cmd_i,
    input  wire logic [7:0] cmd_data_i,
    input  wire logic [7:0] event_set_i,
    input  wire logic       out_queue_nonempty_i,
    input  wire logic       err_queue_nonempty_i,
    input  wire logic       serial_poll_i,
    input  wire logic [7:0] char_i,
    input  wire logic       char_valid_i,
    input  wire logic       suffix_present_i,
    input  wire logic [3:0] suffix_value_i,
    input  wire logic       opt_present_i,
    input  wire logic [7:0] opt_value_i,
    input  wire logic [7:0] opt_default_i,
    output logic            rsp_valid_o,
    output logic [7:0]      rsp_data_o,
    output logic            poll_valid_o,
    output logic [7:0]      poll_data_o,
    output logic            clear_queues_o,
    output logic            service_request_o,
    output logic            tok_valid_o,
    output logic            is_wsp_o,
    output logic            is_digit_o,
    output logic [3:0]      digit_value_o,
    output logic [3:0]      capability_o,
    output logic [7:0]      opt_effective_o
);

    srr_if tk_if ();

    srr_tok u_tok (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .tk        (tk_if.tok)
    );

    assign tk_if.chr         = char_i;
    assign tk_if.chr_vld     = char_valid_i;
    assign tk_if.sfx_present = suffix_present_i;
    assign tk_if.sfx_val     = suffix_value_i;
    assign tk_if.opt_present = opt_present_i;
    assign tk_if.opt_val     = opt_value_i;
    assign tk_if.opt_dflt    = opt_default_i;
    assign tok_valid_o       = tk_if.tok_vld;
    assign is_wsp_o          = tk_if.is_wsp;
    assign is_digit_o        = tk_if.is_digit;
    assign digit_value_o     = tk_if.digit_val;
    assign capability_o      = tk_if.cap_idx;
    assign opt_effective_o   = tk_if.opt_eff;

    function automatic logic is_cmd(input logic v, input srr_cmd_t c, input srr_cmd_t want);
        is_cmd = v && (c == want);
    endfunction : is_cmd

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    srr_byte_t evt_d, evt_en_d, req_en_d, stat_d, rsp_data_d, poll_data_d;
    srr_byte_t evt_q, evt_en_q, req_en_q, stat_q, rsp_data_q, poll_data_q;
    logic      rsp_vld_d, poll_vld_d, cls_d, srq_d;
    logic      rsp_vld_q, poll_vld_q, cls_q, srq_q;
    srr_byte_t stat_low;

    always_comb begin
        evt_d = evt_q;
        // clear by read or clear-status; new events in the same cycle still land
        if (is_cmd(cmd_valid_i, cmd_i, SRR_CMD_EVT_Q)
                || is_cmd(cmd_valid_i, cmd_i, SRR_CMD_CLR_STAT))
            evt_d = `SRR_CLEAR_VAL; // R3
        evt_d = evt_d | (event_set_i & `SRR_EVENT_USED); // R2

        evt_en_d = evt_en_q;
        if (is_cmd(cmd_valid_i, cmd_i, SRR_CMD_EVT_EN_W))
            evt_en_d = cmd_data_i & `SRR_EVENT_USED; // R4
        req_en_d = req_en_q;
        if (is_cmd(cmd_valid_i, cmd_i, SRR_CMD_REQ_EN_W))
            req_en_d = cmd_data_i & `SRR_REQUEST_WMASK; // R8

        // status byte is rebuilt from its sources every cycle, never written
        stat_low = `SRR_CLEAR_VAL; // R7
        stat_low[`SRR_EVENT_SUMMARY_BIT]     = |(evt_q & evt_en_q); // R16
        stat_low[`SRR_MESSAGE_AVAILABLE_BIT] = out_queue_nonempty_i; // R14
        stat_low[`SRR_ERROR_AVAILABLE_BIT]   = err_queue_nonempty_i; // R15
        srq_d = |(stat_low & req_en_q & `SRR_REQUEST_WMASK); // R17
        stat_d = stat_low;
        stat_d[`SRR_MASTER_SUMMARY] = srq_d; // R5 R9

        rsp_vld_d  = 1'b0;
        rsp_data_d = rsp_data_q;
        if (cmd_valid_i) begin
            case (cmd_i)
                SRR_CMD_EVT_Q: begin
                    rsp_vld_d  = 1'b1;
                    rsp_data_d = evt_q; // R3
                end
                SRR_CMD_EVT_EN_Q: begin
                    rsp_vld_d  = 1'b1;
                    rsp_data_d = evt_en_q; // R4
                end
                SRR_CMD_REQ_EN_Q: begin
                    rsp_vld_d  = 1'b1;
                    rsp_data_d = req_en_q; // R8
                end
                SRR_CMD_STAT_Q: begin
                    rsp_vld_d  = 1'b1;
                    rsp_data_d = stat_q; // R6
                end
                default: begin
                    rsp_vld_d  = 1'b0;
                end
            endcase
        end
        // poll path touches no other state, so it can run beside any command
        poll_vld_d  = serial_poll_i; // R6
        poll_data_d = serial_poll_i ? stat_q : poll_data_q; // R6
        cls_d = is_cmd(cmd_valid_i, cmd_i, SRR_CMD_CLR_STAT); // R7
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            evt_q       <= `SRR_EVENT_RST; // R1
            evt_en_q    <= `SRR_MASK_RST; // R4
            req_en_q    <= `SRR_MASK_RST; // R8
            stat_q      <= `SRR_MASK_RST;
            srq_q       <= 1'b0;
            rsp_vld_q   <= 1'b0;
            rsp_data_q  <= `SRR_CLEAR_VAL;
            poll_vld_q  <= 1'b0;
            poll_data_q <= `SRR_CLEAR_VAL;
            cls_q       <= 1'b0;
        end else begin
            evt_q       <= evt_d;
            evt_en_q    <= evt_en_d;
            req_en_q    <= req_en_d;
            stat_q      <= stat_d;
            srq_q       <= srq_d;
            rsp_vld_q   <= rsp_vld_d;
            rsp_data_q  <= rsp_data_d;
            poll_vld_q  <= poll_vld_d;
            poll_data_q <= poll_data_d;
            cls_q       <= cls_d;
        end
    end

    assign rsp_valid_o       = rsp_vld_q;
    assign rsp_data_o        = rsp_data_q;
    assign poll_valid_o      = poll_vld_q;
    assign poll_data_o       = poll_data_q;
    assign clear_queues_o    = cls_q;
    assign service_request_o = srq_q;

    a_evt_read_clear: assert property ( // R3
        cmd_valid_i && (cmd_i == SRR_CMD_EVT_Q || cmd_i == SRR_CMD_CLR_STAT)
        && event_set_i == `SRR_CLEAR_VAL |=> evt_q == `SRR_CLEAR_VAL)
        else $error("event register not cleared");
    a_evt_set_wins: assert property ( // R2
        event_set_i[`SRR_COMMAND_ERROR_FLAG]
        |=> evt_q[`SRR_COMMAND_ERROR_FLAG] && !evt_q[`SRR_EVENT_SPARE_BIT])
        else $error("event lost or unused bit set");
    a_evt_en_write: assert property ( // R4
        cmd_valid_i && cmd_i == SRR_CMD_EVT_EN_W
        |=> evt_en_q == ($past(cmd_data_i) & `SRR_EVENT_USED))
        else $error("event enable write wrong");
    a_evt_en_read: assert property ( // R4
        cmd_valid_i && cmd_i == SRR_CMD_EVT_EN_Q
        |=> rsp_valid_o && rsp_data_o == $past(evt_en_q))
        else $error("event enable query not answered");
    a_req_en_write: assert property ( // R8
        cmd_valid_i && cmd_i == SRR_CMD_REQ_EN_W
        |=> req_en_q == ($past(cmd_data_i) & `SRR_REQUEST_WMASK))
        else $error("request enable write wrong");
    a_evt_summary: assert property ( // R16
        stat_q[`SRR_EVENT_SUMMARY_BIT] == |($past(evt_q) & $past(evt_en_q)))
        else $error("event summary wrong");
    a_queue_bits: assert property ( // R14 R15
        stat_q[`SRR_MESSAGE_AVAILABLE_BIT] == $past(out_queue_nonempty_i)
        && stat_q[`SRR_ERROR_AVAILABLE_BIT] == $past(err_queue_nonempty_i))
        else $error("queue status bits wrong");
    a_stat_unused: assert property ( // R5
        (stat_q & `SRR_STATUS_UNUSED) == `SRR_CLEAR_VAL)
        else $error("unused status bit set");
    a_master_summary: assert property ( // R17
        stat_q[`SRR_MASTER_SUMMARY] == |(stat_q & $past(req_en_q) & `SRR_REQUEST_WMASK)
        && service_request_o == stat_q[`SRR_MASTER_SUMMARY])
        else $error("master summary or request wrong");
    a_query_answer: assert property ( // R6
        cmd_valid_i && cmd_i == SRR_CMD_STAT_Q
        |=> rsp_valid_o && rsp_data_o == $past(stat_q))
        else $error("status query not answered");
    a_poll_answer: assert property ( // R6
        serial_poll_i |=> poll_valid_o && poll_data_o == $past(stat_q)
        && (!rsp_valid_o || $past(cmd_valid_i)))
        else $error("serial poll not answered");
    a_poll_quiet: assert property ( // R6
        serial_poll_i && !cmd_valid_i && event_set_i == `SRR_CLEAR_VAL
        |=> $stable(evt_q) && $stable(evt_en_q) && $stable(req_en_q))
        else $error("serial poll changed a register");
    a_clear_pulse: assert property ( // R7
        cmd_valid_i && cmd_i == SRR_CMD_CLR_STAT |=> clear_queues_o)
        else $error("clear-status not passed to queues");

endmodule : srr_regs

`default_nettype wire

// *** logic/srr_cfg.svh ***
`ifndef SRR_CFG_SVH
`define SRR_CFG_SVH

// event register bit positions
`define SRR_POWER_ON_FLAG               7
`define SRR_USER_REQUEST_FLAG           6
`define SRR_COMMAND_ERROR_FLAG          5
`define SRR_EXECUTION_ERROR_FLAG        4
`define SRR_DEVICE_DEPENDENT_ERROR_FLAG 3
`define SRR_QUERY_ERROR_FLAG            2
`define SRR_EVENT_SPARE_BIT             1
`define SRR_OPERATION_COMPLETE_FLAG     0
// status byte bit positions
`define SRR_MASTER_SUMMARY              6
`define SRR_EVENT_SUMMARY_BIT           5
`define SRR_MESSAGE_AVAILABLE_BIT       4
`define SRR_ERROR_AVAILABLE_BIT         2
// writable / used bit masks
`define SRR_EVENT_USED                  8'hfd
`define SRR_STATUS_UNUSED               8'h8b
`define SRR_REQUEST_WMASK               8'hbf
// reset and clear values
`define SRR_EVENT_RST                   8'h80
`define SRR_MASK_RST                    8'h00
`define SRR_CLEAR_VAL                   8'h00
// character classes
`define SRR_WSP_LO1   8'h00
`define SRR_WSP_HI1   8'h09
`define SRR_WSP_LO2   8'h0b
`define SRR_WSP_HI2   8'h20
`define SRR_DIG_LO    8'h30
`define SRR_DIG_HI    8'h39
// capability index used when a keyword has no suffix
`define SRR_CAP_FIRST 4'h1

`endif

// *** logic/srr_pkg.sv ***
package srr_pkg;

    typedef enum logic [2:0] {
        SRR_CMD_NONE,
        SRR_CMD_EVT_Q,
        SRR_CMD_EVT_EN_W,
        SRR_CMD_EVT_EN_Q,
        SRR_CMD_REQ_EN_W,
        SRR_CMD_REQ_EN_Q,
        SRR_CMD_STAT_Q,
        SRR_CMD_CLR_STAT
    } srr_cmd_t;

    typedef logic [7:0] srr_byte_t;

endpackage : srr_pkg

// *** logic/srr_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface srr_if;
    logic [7:0] chr;
    logic       chr_vld;
    logic       sfx_present;
    logic [3:0] sfx_val;
    logic       opt_present;
    logic [7:0] opt_val;
    logic [7:0] opt_dflt;
    logic       is_wsp;
    logic       is_digit;
    logic [3:0] digit_val;
    logic       tok_vld;
    logic [3:0] cap_idx;
    logic [7:0] opt_eff;

    modport regs (output chr, chr_vld, sfx_present, sfx_val, opt_present, opt_val, opt_dflt,
                  input  is_wsp, is_digit, digit_val, tok_vld, cap_idx, opt_eff);
    modport tok  (input  chr, chr_vld, sfx_present, sfx_val, opt_present, opt_val, opt_dflt,
                  output is_wsp, is_digit, digit_val, tok_vld, cap_idx, opt_eff);
endinterface : srr_if

`default_nettype wire

// *** logic/srr_tok.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "srr_cfg.svh"

module srr_tok
    import srr_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    srr_if.tok        tk
);

    function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (c >= lo) && (c <= hi);
    endfunction : in_range

    logic       wsp_d, dig_d, vld_d;
    logic [3:0] dval_d, cap_d;
    logic [7:0] opt_d;
    logic       wsp_q, dig_q, vld_q;
    logic [3:0] dval_q, cap_q;
    logic [7:0] opt_q;

    always_comb begin
        vld_d  = tk.chr_vld;
        // code 10 (line feed) is the terminator, hence the split range
        wsp_d  = in_range(tk.chr, `SRR_WSP_LO1, `SRR_WSP_HI1)
               | in_range(tk.chr, `SRR_WSP_LO2, `SRR_WSP_HI2); // R10
        dig_d  = in_range(tk.chr, `SRR_DIG_LO, `SRR_DIG_HI); // R11
        dval_d = dig_d ? 4'(tk.chr - `SRR_DIG_LO) : 4'h0; // R11
        cap_d  = tk.sfx_present ? tk.sfx_val : `SRR_CAP_FIRST; // R12
        opt_d  = tk.opt_present ? tk.opt_val : tk.opt_dflt; // R13
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vld_q  <= 1'b0;
            wsp_q  <= 1'b0;
            dig_q  <= 1'b0;
            dval_q <= 4'h0;
            cap_q  <= `SRR_CAP_FIRST;
            opt_q  <= 8'h00;
        end else begin
            vld_q  <= vld_d;
            wsp_q  <= wsp_d;
            dig_q  <= dig_d;
            dval_q <= dval_d;
            cap_q  <= cap_d;
            opt_q  <= opt_d;
        end
    end

    assign tk.tok_vld   = vld_q;
    assign tk.is_wsp    = wsp_q;
    assign tk.is_digit  = dig_q;
    assign tk.digit_val = dval_q;
    assign tk.cap_idx   = cap_q;
    assign tk.opt_eff   = opt_q;

    a_wsp_class: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
        $past(tk.chr_vld) && !$past(reset_i)
        |-> tk.tok_vld && tk.is_wsp == ($past(tk.chr) <= 8'h09
            || ($past(tk.chr) >= 8'h0b && $past(tk.chr) <= 8'h20)))
        else $error("whitespace class wrong");
    a_digit_class: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
        tk.is_digit |-> ($past(tk.chr) >= 8'h30 && $past(tk.chr) <= 8'h39
                         && tk.digit_val == 4'($past(tk.chr) - 8'h30)))
        else $error("digit class wrong");
    a_cap_default: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
        !tk.sfx_present |=> tk.cap_idx == 4'h1)
        else $error("missing suffix did not select first capability");
    a_opt_same: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
        (tk.opt_present && tk.opt_val == tk.opt_dflt) || !tk.opt_present
        |=> tk.opt_eff == $past(tk.opt_dflt))
        else $error("optional parameter forms differ");

endmodule : srr_tok

`default_nettype wire

// *** sim/srr_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module srr_ctrl_model
    import srr_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rsp_valid_i,
    input  wire logic [7:0] rsp_data_i,
    input  wire logic       poll_valid_i,
    input  wire logic [7:0] poll_data_i,
    output var  logic       cmd_valid_o,
    output var  srr_cmd_t   cmd_o,
    output var  logic [7:0] cmd_data_o,
    output var  logic       serial_poll_o
);
    initial begin
        cmd_valid_o   = 1'b0;
        cmd_o         = SRR_CMD_NONE;
        cmd_data_o    = 8'h00;
        serial_poll_o = 1'b0;
    end

    // one-cycle command; data line is inverted afterwards so stale bytes never look valid
    task automatic send(input srr_cmd_t c, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_o       = c;
        cmd_data_o  = d;
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_o       = SRR_CMD_NONE;
        cmd_data_o  = ~d;
    endtask : send

    // answer taken at the edge where the pulse is seen; no answer gives unknown
    task automatic query(input srr_cmd_t c, output logic [7:0] v);
        send(c, 8'h00);
        repeat (4) begin
            if (rsp_valid_i !== 1'b1) begin
                @(posedge ref_clk_i);
                #1;
            end
        end
        v = (rsp_valid_i === 1'b1) ? rsp_data_i : 8'hxx;
    endtask : query

    // status read without a command, as the controller does on a request
    task automatic poll(output logic [7:0] v);
        @(posedge ref_clk_i);
        #1;
        serial_poll_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        serial_poll_o = 1'b0;
        v = (poll_valid_i === 1'b1) ? poll_data_i : 8'hxx;
    endtask : poll
endmodule : srr_ctrl_model

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb
    import srr_pkg::*;
;
    logic       ref_clk, reset, cmd_valid, serial_poll, outq, errq;
    logic       chr_vld, sfx_p, opt_p;
    srr_cmd_t   cmd;
    logic [7:0] cmd_data, ev_set, chr, opt_v, opt_d, rsp_data, poll_data, opt_eff, v;
    logic [3:0] sfx_v, dig_val, cap;
    logic       rsp_valid, poll_valid, clr_q, srq, tok_vld, is_wsp, is_dig;
    int         err_count, n_checks;
    logic [7:0] cs [10] = '{8'h00, 8'h09, 8'h0a, 8'h0b, 8'h20, 8'h21, 8'h2f, 8'h30, 8'h39, 8'h3a};

    srr_regs srr_regs_i (.ref_clk_i(ref_clk), .reset_i(reset), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .cmd_data_i(cmd_data), .event_set_i(ev_set), .out_queue_nonempty_i(outq),
        .err_queue_nonempty_i(errq), .serial_poll_i(serial_poll), .char_i(chr),
        .char_valid_i(chr_vld), .suffix_present_i(sfx_p), .suffix_value_i(sfx_v),
        .opt_present_i(opt_p), .opt_value_i(opt_v), .opt_default_i(opt_d),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .poll_valid_o(poll_valid),
        .poll_data_o(poll_data), .clear_queues_o(clr_q), .service_request_o(srq),
        .tok_valid_o(tok_vld), .is_wsp_o(is_wsp), .is_digit_o(is_dig),
        .digit_value_o(dig_val), .capability_o(cap), .opt_effective_o(opt_eff));

    srr_ctrl_model srr_ctrl_model_i (.ref_clk_i(ref_clk), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .poll_valid_i(poll_valid), .poll_data_i(poll_data),
        .cmd_valid_o(cmd_valid), .cmd_o(cmd), .cmd_data_o(cmd_data),
        .serial_poll_o(serial_poll));

    always #50 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test;
        if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic ev(input logic [7:0] e);
        tick();
        ev_set = e;
        tick();
        ev_set = 8'h00;
        tick();
    endtask : ev

    task automatic q(input srr_cmd_t c, input logic [7:0] exp);
        srr_ctrl_model_i.query(c, v);
        chk(v, exp);
    endtask : q

    // classes worked out from plain code ranges, not from any design table
    task automatic tok(input logic [7:0] c);
        logic       w;
        logic       d;
        logic [3:0] dv;
        chr     = c;
        chr_vld = 1'b1;
        tick();
        w  = (c <= 8'd9) || (c >= 8'd11 && c <= 8'd32);
        d  = (c >= 8'd48 && c <= 8'd57);
        dv = d ? 4'(c - 8'h30) : 4'h0;
        chk({1'b0, tok_vld, is_wsp, is_dig, dig_val}, {1'b0, 1'b1, w, d, dv});
    endtask : tok

    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        {ref_clk, outq, errq, chr_vld, sfx_p, opt_p} = '0;
        {ev_set, chr, opt_v, opt_d, sfx_v, err_count, n_checks} = '0;
        reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        q(SRR_CMD_EVT_EN_Q, 8'h00);
        q(SRR_CMD_REQ_EN_Q, 8'h00);
        q(SRR_CMD_EVT_Q, 8'h80);
        q(SRR_CMD_EVT_Q, 8'h00);
        q(SRR_CMD_STAT_Q, 8'h00);
        srr_ctrl_model_i.send(SRR_CMD_EVT_EN_W, 8'hff);
        q(SRR_CMD_EVT_EN_Q, 8'hfd);
        srr_ctrl_model_i.send(SRR_CMD_REQ_EN_W, 8'hff);
        q(SRR_CMD_REQ_EN_Q, 8'hbf);
        ev(8'h20);
        tick();
        chk(srq, 1'b1);
        q(SRR_CMD_STAT_Q, 8'h60);
        srr_ctrl_model_i.poll(v);
        chk(v, 8'h60);
        q(SRR_CMD_EVT_Q, 8'h20);
        q(SRR_CMD_STAT_Q, 8'h00);
        chk(srq, 1'b0);
        outq = 1'b1;
        q(SRR_CMD_STAT_Q, 8'h50);
        outq = 1'b0;
        errq = 1'b1;
        q(SRR_CMD_STAT_Q, 8'h44);
        srr_ctrl_model_i.send(SRR_CMD_EVT_EN_W, 8'h00);
        q(SRR_CMD_EVT_EN_Q, 8'h00);
        ev(8'h21);
        q(SRR_CMD_STAT_Q, 8'h44);
        srr_ctrl_model_i.send(SRR_CMD_CLR_STAT, 8'h00);
        // the clear pulse stands only until the next edge, so look at once
        chk(clr_q, 1'b1);
        errq = 1'b0;
        q(SRR_CMD_EVT_Q, 8'h00);
        q(SRR_CMD_STAT_Q, 8'h00);
        srr_ctrl_model_i.send(SRR_CMD_REQ_EN_W, 8'h00);
        q(SRR_CMD_REQ_EN_Q, 8'h00);
        // startup values must come back after a mid-run reset, whatever was written
        srr_ctrl_model_i.send(SRR_CMD_EVT_EN_W, 8'h24);
        srr_ctrl_model_i.send(SRR_CMD_REQ_EN_W, 8'h10);
        q(SRR_CMD_REQ_EN_Q, 8'h10);
        reset = 1'b1;
        repeat (2) tick();
        reset = 1'b0;
        q(SRR_CMD_EVT_EN_Q, 8'h00);
        q(SRR_CMD_REQ_EN_Q, 8'h00);
        q(SRR_CMD_EVT_Q, 8'h80);
        chk(srq, 1'b0);
        foreach (cs[i]) tok(cs[i]);
        chr_vld = 1'b0;
        // absent suffix and absent option must ignore whatever sits on the value lines
        sfx_v = 4'h7;
        opt_v = 8'h5a;
        opt_d = 8'h11;
        tick();
        chk({4'h0, cap}, 8'h01);
        chk(opt_eff, 8'h11);
        sfx_p = 1'b1;
        sfx_v = 4'h3;
        opt_p = 1'b1;
        tick();
        chk({4'h0, cap}, 8'h03);
        chk(opt_eff, 8'h5a);
        end_of_test();
    end
endmodule : tb

`default_nettype wire
